/* File: core/cwd_decoder.sv */
/*
 Configuration word decoder: latches the first configuration word once at
 reset release and drives the static option signals it selects. Exposes the
 word and load status over an Avalon-MM slave with waitrequest.
 Assumes a configuration memory read port on ref_clk and pins from outside.
*/
// How it works
// - A programmed configuration bit reads 0 and an erased one reads 1, and outputs decode so.
// - The word is fetched from configuration address 2007h and decoded from there.
// - Space 2000h-3FFFh is reachable only in programming mode, never in normal run.
// - Bits 15 to 13 always read back as 1.
// - Bit 12 high frees the programming pins as I/O; low reserves them for the debugger.
// - Bit 11 high enables the fail-safe clock monitor.
// - Bit 10 high enables internal/external oscillator switchover.
// - Bits 9-8 choose brown-out: 11 always, 10 run only, 01 software bit, 00 off.
// - Bit 7 low turns on data memory protection.
// - Bit 6 low turns on program memory protection.
// - Bit 5 high makes the pin an active-low reset, low a digital input with reset inactive.
// - Bit 4 high disables the power-up timer, low enables it.
// - Bit 3 high forces the watchdog on; low leaves it to the software enable bit.
`timescale 1ns/10ps
module cwd_decoder (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Avalon-MM slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Configuration memory
	output logic [15:0] cfg_mem_addr,
	input wire logic [15:0] cfg_mem_rdata,
	input wire logic prog_mode,
	// Pins from outside
	input wire logic reset_pin_in,
	// Decoded options
	output logic debugger_en,
	output logic prog_pins_gpio,
	output logic clock_fail_monitor_en,
	output logic osc_switchover_en,
	output logic [1:0] brownout_policy,
	output logic brownout_run_en,
	output logic brownout_sleep_en,
	output logic data_protect_en,
	output logic program_protect_en,
	output logic reset_pin_is_mclr,
	output logic master_reset_n,
	output logic reset_pin_digital,
	output logic powerup_timer_en,
	output logic watchdog_en,
	output logic [2:0] oscillator_select,
	output logic cfg_loaded,
	output logic cfg_space_access_ok
);
	import cwd_pkg::*;

	typedef enum logic [1:0] {CWD_IDLE, CWD_FETCH, CWD_RUN} cwd_state_t;

	cwd_state_t state_r;
	logic [15:0] word_r;
	logic [1:0] swctl_r;
	logic pin_s1_r;
	logic pin_s2_r;
	logic prog_s1_r;
	logic prog_s2_r;
	logic rd_ack_r;
	logic [31:0] rdata_r;
	logic sw_brownout_en;
	logic watchdog_sw_en;

	cwd_fetch_if fif ();

	cwd_fetch u_fetch (
		.ref_clk(ref_clk),
		.rst(rst),
		.mem_addr(cfg_mem_addr),
		.mem_rdata(cfg_mem_rdata),
		.fif(fif)
	);

	assign fif.start = (state_r == CWD_FETCH);

	// Load sequence; the word is taken once, right after reset release, and
	// never again until the next reset, so consumers see a static value.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_r <= CWD_IDLE;
		end else begin
			unique case (state_r)
				CWD_IDLE: state_r <= CWD_FETCH;
				CWD_FETCH: if (fif.done) state_r <= CWD_RUN;
				CWD_RUN: state_r <= CWD_RUN;
				default: state_r <= CWD_IDLE;
			endcase
		end
	end

	// Erased value until loaded, so every option starts at its unprogrammed meaning.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			word_r <= CWD_ERASED;
		end else if (state_r == CWD_FETCH && fif.done) begin
			word_r <= {CWD_UNIMPL_ONES, fif.word[CWD_UNIMPL_LSB-1:0]};
		end
	end

	// Pins from outside pass two flip-flops before use.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pin_s1_r <= 1'b1;
			pin_s2_r <= 1'b1;
			prog_s1_r <= 1'b0;
			prog_s2_r <= 1'b0;
		end else begin
			pin_s1_r <= reset_pin_in;
			pin_s2_r <= pin_s1_r;
			prog_s1_r <= prog_mode;
			prog_s2_r <= prog_s1_r;
		end
	end

	// Software-owned enables standing in for the power and watchdog control bits.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			swctl_r <= CWD_SWCTL_RESET;
		end else if (avs_write && avs_address == CWD_REG_SWCTL) begin
			swctl_r <= avs_writedata[1:0];
		end
	end
	assign sw_brownout_en = swctl_r[0];
	assign watchdog_sw_en = swctl_r[1];

	assign cfg_loaded = (state_r == CWD_RUN);
	// The space is only open while programming; a running part refuses it.
	assign cfg_space_access_ok = prog_s2_r && !cfg_loaded;

	assign prog_pins_gpio = word_r[CWD_BIT_DEBUG];
	assign debugger_en = !word_r[CWD_BIT_DEBUG];
	assign clock_fail_monitor_en = word_r[CWD_BIT_FCM];
	assign osc_switchover_en = word_r[CWD_BIT_OSC_SWITCHOVER_EN];
	assign brownout_policy = word_r[CWD_BOR_LSB+1:CWD_BOR_LSB];

	always_comb begin
		brownout_run_en = 1'b0;
		brownout_sleep_en = 1'b0;
		unique case (brownout_policy)
			CWD_BOR_ALWAYS: begin
				brownout_run_en = 1'b1;
				brownout_sleep_en = 1'b1;
			end
			CWD_BOR_RUN_ONLY: begin
				brownout_run_en = 1'b1;
			end
			CWD_BOR_SOFTWARE: begin
				brownout_run_en = sw_brownout_en;
				brownout_sleep_en = sw_brownout_en;
			end
			CWD_BOR_OFF: begin
			end
		endcase
	end

	assign data_protect_en = !word_r[CWD_BIT_DPROT];
	assign program_protect_en = !word_r[CWD_BIT_PPROT];
	assign reset_pin_is_mclr = word_r[CWD_BIT_RSTPIN];
	assign reset_pin_digital = !word_r[CWD_BIT_RSTPIN];
	assign master_reset_n = reset_pin_is_mclr ? pin_s2_r : 1'b1;
	assign powerup_timer_en = !word_r[CWD_BIT_PWRT];
	assign watchdog_en = word_r[CWD_BIT_WDT] | watchdog_sw_en;
	assign oscillator_select = word_r[CWD_OSC_LSB+2:CWD_OSC_LSB];

	// Reads take one wait cycle so read data comes from a flip-flop.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rd_ack_r <= 1'b0;
			rdata_r <= CWD_UNMAPPED_RD;
		end else begin
			rd_ack_r <= avs_read && !rd_ack_r;
			if (avs_read && !rd_ack_r) begin
				unique case (avs_address)
					CWD_REG_CONFIG: rdata_r <= {16'h0000, word_r};
					CWD_REG_STATUS: rdata_r <= {30'h0, cfg_space_access_ok, cfg_loaded};
					CWD_REG_SWCTL: rdata_r <= {30'h0, swctl_r};
					default: rdata_r <= CWD_UNMAPPED_RD;
				endcase
			end
		end
	end
	assign avs_readdata = rdata_r;
	assign avs_waitrequest = avs_read && !rd_ack_r;

	// Word register and load sequence.
	AST_ERASED_AT_RESET: assert property (@(posedge ref_clk) disable iff (rst)
		!cfg_loaded |-> word_r == CWD_ERASED)
		else $error("word not erased before load");

	AST_FIXED_ADDR: assert property (@(posedge ref_clk) disable iff (rst)
		cfg_mem_addr == CWD_CFG_WORD_ADDR)
		else $error("fetch address wrong");

	AST_FETCH_IF_ADDR: assert property (@(posedge ref_clk) disable iff (rst)
		fif.addr == CWD_CFG_WORD_ADDR)
		else $error("fetch handshake address wrong");

	AST_FETCH_TAKES_WORD: assert property (@(posedge ref_clk) disable iff (rst)
		state_r == CWD_FETCH && fif.done |=> word_r[12:0] == $past(fif.word[12:0]))
		else $error("fetched word not latched");

	AST_SPACE_CLOSED: assert property (@(posedge ref_clk) disable iff (rst)
		cfg_loaded |-> !cfg_space_access_ok)
		else $error("space open in run");

	AST_SPACE_NEEDS_PROG: assert property (@(posedge ref_clk) disable iff (rst)
		cfg_space_access_ok |-> prog_s2_r)
		else $error("space open outside programming");

	AST_TOP_ONES: assert property (@(posedge ref_clk) disable iff (rst)
		word_r[15:13] == 3'h7)
		else $error("unimplemented bits not one");

	AST_STATE_LEGAL: assert property (@(posedge ref_clk) disable iff (rst)
		state_r inside {CWD_IDLE, CWD_FETCH, CWD_RUN})
		else $error("load state illegal");

	AST_LOADED_AFTER_FETCH: assert property (@(posedge ref_clk) disable iff (rst)
		cfg_loaded |-> fif.done)
		else $error("loaded without a fetch");

	AST_STABLE: assert property (@(posedge ref_clk) disable iff (rst)
		cfg_loaded |=> $stable(word_r) && cfg_loaded)
		else $error("word changed in run");

	AST_LOAD_TIME: assert property (@(posedge ref_clk) disable iff (rst)
		$fell(rst) |-> ##[1:5] cfg_loaded)
		else $error("load too slow");

	// Decoded options; every output is checked against the field that owns it.
	AST_DEBUG_PINS: assert property (@(posedge ref_clk) disable iff (rst)
		debugger_en != prog_pins_gpio && debugger_en == !word_r[12])
		else $error("debug decode");

	AST_FCM_OSC_SWITCHOVER_EN: assert property (@(posedge ref_clk) disable iff (rst)
		clock_fail_monitor_en == word_r[11] && osc_switchover_en == word_r[10])
		else $error("clock option decode");

	AST_OSC_SWITCHOVER_EN: assert property (@(posedge ref_clk) disable iff (rst)
		cfg_loaded && word_r[10] |-> osc_switchover_en)
		else $error("switchover decode");

	AST_BOR_FIELD: assert property (@(posedge ref_clk) disable iff (rst)
		brownout_policy == word_r[9:8])
		else $error("brownout field wrong");

	AST_BOR_ALWAYS: assert property (@(posedge ref_clk) disable iff (rst)
		brownout_policy == 2'h3 |-> brownout_run_en && brownout_sleep_en)
		else $error("brownout always decode");

	AST_BOR_RUN_ONLY: assert property (@(posedge ref_clk) disable iff (rst)
		brownout_policy == 2'h2 |-> brownout_run_en && !brownout_sleep_en)
		else $error("brownout run-only decode");

	AST_BOR_SOFT: assert property (@(posedge ref_clk) disable iff (rst)
		brownout_policy == 2'h1 |->
			brownout_run_en == swctl_r[0] && brownout_sleep_en == swctl_r[0])
		else $error("brownout software decode");

	AST_BOR_OFF: assert property (@(posedge ref_clk) disable iff (rst)
		brownout_policy == 2'h0 |-> !brownout_run_en && !brownout_sleep_en)
		else $error("brownout off decode");

	AST_PROTECT: assert property (@(posedge ref_clk) disable iff (rst)
		data_protect_en == !word_r[7] && program_protect_en == !word_r[6])
		else $error("protect decode");

	AST_RESET_PIN: assert property (@(posedge ref_clk) disable iff (rst)
		!word_r[5] |-> master_reset_n && reset_pin_digital)
		else $error("reset pin decode");

	AST_MCLR_PASS: assert property (@(posedge ref_clk) disable iff (rst)
		word_r[5] |-> master_reset_n == pin_s2_r && !reset_pin_digital)
		else $error("reset pin not passed through");

	AST_PIN_EXCLUSIVE: assert property (@(posedge ref_clk) disable iff (rst)
		reset_pin_is_mclr != reset_pin_digital)
		else $error("reset pin has two functions");

	AST_PWRT: assert property (@(posedge ref_clk) disable iff (rst)
		powerup_timer_en == !word_r[4])
		else $error("power-up timer decode");

	AST_WDT: assert property (@(posedge ref_clk) disable iff (rst)
		word_r[3] |-> watchdog_en)
		else $error("watchdog not forced");

	AST_WDT_SOFT: assert property (@(posedge ref_clk) disable iff (rst)
		!word_r[3] |-> watchdog_en == swctl_r[1])
		else $error("watchdog software decode");

	AST_OSC_FIELD: assert property (@(posedge ref_clk) disable iff (rst)
		oscillator_select == word_r[2:0])
		else $error("oscillator field wrong");

	// Register bus: one wait state on reads, none on writes.
	AST_READ_WAITS: assert property (@(posedge ref_clk) disable iff (rst)
		avs_read && !rd_ack_r |-> avs_waitrequest)
		else $error("read answered without a wait");

	AST_READ_ONE_WAIT: assert property (@(posedge ref_clk) disable iff (rst)
		avs_read && avs_waitrequest |=> !avs_read || !avs_waitrequest)
		else $error("read waited too long");

	AST_WRITE_NO_WAIT: assert property (@(posedge ref_clk) disable iff (rst)
		avs_write && !avs_read |-> !avs_waitrequest)
		else $error("write stalled");

	AST_RD_CONFIG: assert property (@(posedge ref_clk) disable iff (rst)
		avs_read && avs_waitrequest && avs_address == CWD_REG_CONFIG |=>
			avs_readdata == {16'h0000, $past(word_r)})
		else $error("config readback wrong");

	AST_RD_STATUS: assert property (@(posedge ref_clk) disable iff (rst)
		avs_read && avs_waitrequest && avs_address == CWD_REG_STATUS |=>
			avs_readdata == {30'h0, $past(cfg_space_access_ok), $past(cfg_loaded)})
		else $error("status readback wrong");

	AST_SWCTL_WRITE: assert property (@(posedge ref_clk) disable iff (rst)
		avs_write && avs_address == CWD_REG_SWCTL |=> swctl_r == $past(avs_writedata[1:0]))
		else $error("software control write lost");

	AST_SWCTL_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
		!(avs_write && avs_address == CWD_REG_SWCTL) |=> $stable(swctl_r))
		else $error("software control changed without a write");

	COV_LOADED: cover property (@(posedge ref_clk) disable iff (rst) $rose(cfg_loaded));
	COV_BOR_SW: cover property (@(posedge ref_clk) disable iff (rst)
		brownout_policy == 2'h1 && brownout_run_en);
	COV_DEBUG: cover property (@(posedge ref_clk) disable iff (rst) cfg_loaded && debugger_en);
	COV_READ: cover property (@(posedge ref_clk) disable iff (rst) avs_read && !avs_waitrequest);
	COV_SPACE_OPEN: cover property (@(posedge ref_clk) disable iff (rst) cfg_space_access_ok);
endmodule

/* File: core/cwd_pkg.sv */
/*
 Package for the configuration word decoder: word address, field positions,
 policy encodings and register map for the Avalon-MM slave.
 Assumes nothing of its surroundings beyond a SystemVerilog compiler.
*/
package cwd_pkg;
	localparam logic [15:0] CWD_CFG_SPACE_LO = 16'h2000;
	localparam logic [15:0] CWD_CFG_SPACE_HI = 16'h3fff;
	localparam logic [15:0] CWD_CFG_WORD_ADDR = 16'h2007;
	localparam int CWD_WORD_W = 16;
	localparam logic [15:0] CWD_ERASED = 16'hffff;
	localparam logic [2:0] CWD_UNIMPL_ONES = 3'h7;
	localparam int CWD_UNIMPL_LSB = 13;
	localparam int CWD_BIT_DEBUG = 12;
	localparam int CWD_BIT_FCM = 11;
	localparam int CWD_BIT_OSC_SWITCHOVER_EN = 10;
	localparam int CWD_BOR_LSB = 8;
	localparam int CWD_BIT_DPROT = 7;
	localparam int CWD_BIT_PPROT = 6;
	localparam int CWD_BIT_RSTPIN = 5;
	localparam int CWD_BIT_PWRT = 4;
	localparam int CWD_BIT_WDT = 3;
	localparam int CWD_OSC_LSB = 0;
	localparam logic [1:0] CWD_BOR_ALWAYS = 2'h3;
	localparam logic [1:0] CWD_BOR_RUN_ONLY = 2'h2;
	localparam logic [1:0] CWD_BOR_SOFTWARE = 2'h1;
	localparam logic [1:0] CWD_BOR_OFF = 2'h0;
	// Avalon word addresses (byte address = 4 * index).
	localparam logic [3:0] CWD_REG_CONFIG = 4'h0;
	localparam logic [3:0] CWD_REG_STATUS = 4'h1;
	localparam logic [3:0] CWD_REG_SWCTL = 4'h2;
	localparam logic [31:0] CWD_UNMAPPED_RD = 32'h00000000;
	localparam logic [1:0] CWD_SWCTL_RESET = 2'h0;
	localparam int CWD_FETCH_CYCLES = 2;
endpackage

/* File: core/cwd_fetch_if.sv */
/*
 Interface carrying the configuration-memory fetch between the decoder top
 and its fetch engine. Assumes one clock shared by both ends.
*/
`timescale 1ns/10ps
interface cwd_fetch_if;
	logic start;
	logic done;
	logic [15:0] addr;
	logic [15:0] word;
	modport engine (input start, output done, output addr, output word);
	modport user (output start, input done, input addr, input word);
endinterface

/* File: core/cwd_fetch.sv */
/*
 Fetch engine: reads one word of configuration memory at the fixed
 configuration address, presented as a synchronous read port.
 Assumes memory data is valid the cycle after the address is shown.
*/
`timescale 1ns/10ps
module cwd_fetch (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Memory port
	output logic [15:0] mem_addr,
	input wire logic [15:0] mem_rdata,
	// Fetch handshake
	cwd_fetch_if.engine fif
);
	import cwd_pkg::*;
	logic [1:0] cnt_r;
	logic done_r;
	logic [15:0] word_r;

	assign mem_addr = CWD_CFG_WORD_ADDR;
	assign fif.addr = CWD_CFG_WORD_ADDR;
	assign fif.done = done_r;
	assign fif.word = word_r;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_r <= 2'h0;
			done_r <= 1'b0;
			word_r <= CWD_ERASED;
		end else if (fif.start && !done_r) begin
			if (cnt_r == 2'(CWD_FETCH_CYCLES - 1)) begin
				word_r <= mem_rdata;
				done_r <= 1'b1;
			end else begin
				cnt_r <= cnt_r + 2'h1;
			end
		end
	end
endmodule

/* File: verification/cwd_cfgmem_model.sv */
/*
 Model of configuration memory as a device programmer leaves it: one word at
 the configuration address, written only while programming mode is held.
 Assumes one clock shared with the decoder and a synchronous read port.
*/
`timescale 1ns/10ps
module cwd_cfgmem_model (
	// Clock
	input wire logic ref_clk,
	// Read port
	input wire logic [15:0] addr,
	output logic [15:0] rdata,
	// Programmer side
	input wire logic prog_mode,
	input wire logic prog_we,
	input wire logic [15:0] prog_data
);
	import cwd_pkg::*;
	logic [15:0] word_r = CWD_ERASED;
	initial rdata = CWD_ERASED;
	always @(posedge ref_clk) begin
		if (prog_mode && prog_we) begin
			word_r <= prog_data;
		end
	end
	// Other addresses toggle, so a decoder fetching the wrong place never sees a steady word.
	always @(posedge ref_clk) begin
		if (addr == CWD_CFG_WORD_ADDR) begin
			rdata <= word_r;
		end else begin
			rdata <= ~rdata;
		end
	end
endmodule

/* File: verification/tb.sv */
/*
 Self-checking bench for the configuration word decoder.
 Assumes the decoder and the memory model are compiled before it.
*/
`timescale 1ns/10ps
`define CHK(g, x) begin checks_done++; if ((g) !== (x)) begin err_count++; \
$display("ERROR t=%0t got=%h exp=%h", $time, (g), (x)); end end
module tb;
	import cwd_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [15:0] cfg_mem_addr;
	logic [15:0] cfg_mem_rdata;
	logic prog_mode = 1'b0;
	logic prog_we = 1'b0;
	logic reset_pin_in = 1'b1;
	logic [15:0] prog_data = 16'h0;
	logic debugger_en, prog_pins_gpio, clock_fail_monitor_en, osc_switchover_en;
	logic [1:0] brownout_policy;
	logic brownout_run_en, brownout_sleep_en, data_protect_en, program_protect_en;
	logic reset_pin_is_mclr, master_reset_n, reset_pin_digital, powerup_timer_en, watchdog_en;
	logic [2:0] oscillator_select;
	logic cfg_loaded, cfg_space_access_ok;
	logic [31:0] rd;
	logic [13:0] dexp;
	int err_count = 0;
	int checks_done = 0;
	int cycles = 0;
	int seed = 52;
	int q[$];
	int e, sw, pin, n;

	cwd_decoder cwd_decoder_i (.ref_clk, .rst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_readdata, .avs_waitrequest, .cfg_mem_addr, .cfg_mem_rdata,
		.prog_mode, .reset_pin_in, .debugger_en, .prog_pins_gpio, .clock_fail_monitor_en,
		.osc_switchover_en, .brownout_policy, .brownout_run_en, .brownout_sleep_en,
		.data_protect_en, .program_protect_en, .reset_pin_is_mclr, .master_reset_n,
		.reset_pin_digital, .powerup_timer_en, .watchdog_en, .oscillator_select,
		.cfg_loaded, .cfg_space_access_ok);
	cwd_cfgmem_model cwd_cfgmem_model_i (.ref_clk, .addr(cfg_mem_addr),
		.rdata(cfg_mem_rdata), .prog_mode, .prog_we, .prog_data);

	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end

	task automatic results();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// The request is held until an edge with waitrequest low, then dropped.
	task automatic bus_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			err_count++;
			results();
		end
	end

	task automatic check_outputs();
		dexp = {~e[12], e[12], e[11], e[10], e[9:8], ~e[7], ~e[6], e[5], ~e[5], ~e[4], e[2:0]};
		`CHK({debugger_en, prog_pins_gpio, clock_fail_monitor_en, osc_switchover_en,
			brownout_policy, data_protect_en, program_protect_en, reset_pin_is_mclr,
			reset_pin_digital, powerup_timer_en, oscillator_select}, dexp)
	endtask

	initial begin
		for (int i = 0; i < 8; i++) begin
			e = $random(seed);
			e[9:8] = i[1:0];
			q.push_back(e & 'hffff);
			@(posedge ref_clk);
			rst <= 1'b1;
			prog_mode <= 1'b1;
			prog_we <= 1'b1;
			prog_data <= 16'(q[$]);
			@(posedge ref_clk);
			prog_we <= 1'b0;
			@(negedge ref_clk);
			`CHK(cfg_loaded, 1'b0)
			`CHK(prog_pins_gpio, 1'b1)
			@(posedge ref_clk);
			rst <= 1'b0;
			n = 0;
			do begin
				@(negedge ref_clk);
				n++;
				if (n == 3) `CHK(cfg_space_access_ok, 1'b1)
			end while (cfg_loaded !== 1'b1 && n < 8);
			`CHK(n <= 5, 1'b1)
			`CHK(cfg_space_access_ok, 1'b0)
			`CHK(cfg_mem_addr, CWD_CFG_WORD_ADDR)
			e = q[$] | 'he000;
			sw = $random(seed) & 3;
			pin = $random(seed) & 1;
			check_outputs();
			// Reprogram memory after load; the latched word must not follow it.
			@(posedge ref_clk);
			prog_we <= 1'b1;
			prog_data <= ~16'(q[$]);
			reset_pin_in <= pin[0];
			@(posedge ref_clk);
			prog_we <= 1'b0;
			prog_mode <= 1'b0;
			bus_xfer(1'b0, CWD_REG_SWCTL, 32'h0);
			`CHK(rd, {30'h0, CWD_SWCTL_RESET})
			bus_xfer(1'b1, CWD_REG_SWCTL, 32'(sw));
			bus_xfer(1'b1, CWD_REG_CONFIG, 32'($random(seed)));
			bus_xfer(1'b0, CWD_REG_CONFIG, 32'h0);
			`CHK(rd, 32'(e))
			bus_xfer(1'b0, CWD_REG_STATUS, 32'h0);
			`CHK(rd, 32'h00000001)
			bus_xfer(1'b0, CWD_REG_SWCTL, 32'h0);
			`CHK(rd, 32'(sw))
			bus_xfer(1'b0, 4'h3 + i[3:0], 32'h0);
			`CHK(rd, CWD_UNMAPPED_RD)
			@(negedge ref_clk);
			check_outputs();
			`CHK({brownout_run_en, brownout_sleep_en},
				e[9] ? {1'b1, e[8]} : (e[8] ? {sw[0], sw[0]} : 2'b00))
			`CHK(watchdog_en, e[3] | sw[1])
			`CHK(master_reset_n, e[5] ? pin[0] : 1'b1)
		end
		results();
	end
endmodule
